//--- common/bac_pkg.sv
// package for the baseband acquisition configuration bank
package bac_pkg;

	localparam int BAC_DATA_W = 32;
	localparam int BAC_ADDR_W = 9;
	localparam int BAC_REG_W = 8;
	localparam int BAC_NUM_REGS = 11;
	localparam int BAC_SLOT_W = 4;

	// printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] BAC_IDX_TONE_THR = 8'h4a;
	localparam logic [7:0] BAC_IDX_SNR_ONE = 8'h4c;
	localparam logic [7:0] BAC_IDX_SNR_TWO = 8'h4e;
	localparam logic [7:0] BAC_IDX_DC_THR = 8'h50;
	localparam logic [7:0] BAC_IDX_PRE_LEAD = 8'h52;
	localparam logic [7:0] BAC_IDX_PRE_LAG = 8'h54;
	localparam logic [7:0] BAC_IDX_PAY_LEAD = 8'h56;
	localparam logic [7:0] BAC_IDX_PAY_LAG = 8'h58;
	localparam logic [7:0] BAC_IDX_FAR_TARGET = 8'h5a;
	localparam logic [7:0] BAC_IDX_ACQ_TIMELINE = 8'h5c;
	localparam logic [7:0] BAC_IDX_ACQ_THR = 8'h5e;
	localparam logic [7:0] BAC_IDX_STEP = 8'h02;

	// slot numbers in the storage array
	localparam logic [3:0] BAC_SLOT_TONE_THR = 4'h0;
	localparam logic [3:0] BAC_SLOT_SNR_ONE = 4'h1;
	localparam logic [3:0] BAC_SLOT_SNR_TWO = 4'h2;
	localparam logic [3:0] BAC_SLOT_DC_THR = 4'h3;
	localparam logic [3:0] BAC_SLOT_PRE_LEAD = 4'h4;
	localparam logic [3:0] BAC_SLOT_PRE_LAG = 4'h5;
	localparam logic [3:0] BAC_SLOT_PAY_LEAD = 4'h6;
	localparam logic [3:0] BAC_SLOT_PAY_LAG = 4'h7;
	localparam logic [3:0] BAC_SLOT_FAR_TARGET = 4'h8;
	localparam logic [3:0] BAC_SLOT_ACQ_TIMELINE = 4'h9;
	localparam logic [3:0] BAC_SLOT_ACQ_THR = 4'ha;

	localparam logic [7:0] BAC_REG_RESET = 8'h00;

	// field positions
	localparam int BAC_BIT_FORCE_DEFAULT = 6;
	localparam int BAC_BIT_FORCE_CALC = 5;
	localparam int BAC_TONE_THR_MSB = 4;
	localparam int BAC_SNR_ONE_MSB = 3;
	localparam int BAC_SNR_TWO_MSB = 4;
	localparam int BAC_SIX_MSB = 5;
	localparam int BAC_BIT_LONG_DISABLE = 7;
	localparam int BAC_BIT_DIV_METRIC = 6;
	localparam int BAC_BIT_FAR_DISABLE = 7;
	localparam int BAC_BIT_ED_AND_SQ = 6;

	// false alarm target: rate = n * 32 / 2^16, counted over a window of 2^16 samples
	localparam int BAC_FAR_SCALE_SHIFT = 5;
	localparam int BAC_FAR_WINDOW = 65536;
	localparam int BAC_FAR_CNT_W = 17;
	localparam logic [5:0] BAC_SQ_THR_MAX = 6'h3f;
	localparam logic [5:0] BAC_SQ_THR_MIN = 6'h00;
	localparam logic [5:0] BAC_SQ_THR_STEP = 6'h01;

	typedef struct packed {
		logic read;
		logic write;
		logic [BAC_ADDR_W-1:0] address;
		logic [BAC_DATA_W-1:0] writedata;
	} bac_avm_req_t;

	typedef struct packed {
		logic [7:0] rssi;
		logic [7:0] measured_noise_level;
		logic tone_interferer_present;
		logic delay_spread_low;
		logic [7:0] energy_detection_threshold;
		logic sample_valid;
		logic [5:0] signal_quality_metric;
		logic false_alarm;
	} bac_rx_in_t;

	typedef struct packed {
		logic use_default_weights;
		logic dc_offset_comp_enable;
		logic energy_detection;
		logic acquisition_detect;
		logic [5:0] sq1_threshold_live;
		logic [5:0] sq1_threshold_verify;
		logic long_preamble_disable;
		logic diversity_metric_rssi;
		logic [5:0] preamble_lead;
		logic [5:0] preamble_lag;
		logic [5:0] payload_lead;
		logic [5:0] payload_lag;
	} bac_ctrl_out_t;

endpackage : bac_pkg

//--- rtl/bac_config_bank.sv
// baseband acquisition configuration bank with its control decisions
`timescale 1ns/1ps
`default_nettype none
module bac_config_bank #(
	parameter int FAR_WINDOW = bac_pkg::BAC_FAR_WINDOW
) (
	input wire logic clk,
	input wire logic nrst,
	input wire bac_pkg::bac_avm_req_t avm_req,
	output logic [bac_pkg::BAC_DATA_W-1:0] avm_readdata,
	output logic avm_waitrequest,
	input wire bac_pkg::bac_rx_in_t rx_in,
	output bac_pkg::bac_ctrl_out_t ctrl_out
);
	import bac_pkg::*;

	logic [BAC_REG_W-1:0] regs_r [BAC_NUM_REGS];
	logic wait_r;
	logic [BAC_DATA_W-1:0] rdata_r;
	logic use_default_r;
	logic dc_comp_r;
	logic ed_r;
	logic acq_r;
	logic [5:0] sq_thr_r;
	logic [BAC_FAR_CNT_W-1:0] win_cnt_r;
	logic [BAC_FAR_CNT_W-1:0] alarm_cnt_r;
	logic req;
	logic hit;
	logic [BAC_SLOT_W-1:0] slot;
	logic wr_en;
	logic [BAC_FAR_CNT_W-1:0] far_target;
	logic win_end;
	logic [7:0] tone_thr;
	logic [7:0] snr_one_thr;
	logic [7:0] snr_two_thr;
	logic [7:0] dc_thr;
	logic tone_low;
	logic snr_one_low;
	logic snr_two_low;
	logic normal_default;

	// address to slot decode
	function automatic logic [BAC_SLOT_W:0] bac_decode(input logic [BAC_ADDR_W-1:0] addr);
		logic [7:0] idx;
		logic [7:0] rel;
		bac_decode = {1'b0, BAC_SLOT_TONE_THR};
		idx = {1'b0, addr[BAC_ADDR_W-1:2]};
		rel = idx - BAC_IDX_TONE_THR;
		if (addr[1:0] == 2'b00 && idx >= BAC_IDX_TONE_THR && idx <= BAC_IDX_ACQ_THR
				&& rel[0] == 1'b0) begin
			bac_decode = {1'b1, rel[BAC_SLOT_W:1]};
		end
	endfunction : bac_decode

	// strength above threshold plus noise level
	function automatic logic bac_above(input logic [7:0] rssi, input logic [7:0] thr,
			input logic [7:0] noise);
		bac_above = {1'b0, rssi} > ({1'b0, thr} + {1'b0, noise});
	endfunction : bac_above

	// strength strictly below threshold plus noise level, no wrap of the sum
	function automatic logic bac_below(input logic [7:0] rssi, input logic [7:0] thr,
			input logic [7:0] noise);
		bac_below = {1'b0, rssi} < ({1'b0, thr} + {1'b0, noise});
	endfunction : bac_below

	// threshold fields widened to the strength scale
	assign tone_thr = {3'b000, regs_r[BAC_SLOT_TONE_THR][BAC_TONE_THR_MSB:0]};
	assign snr_one_thr = {4'h0, regs_r[BAC_SLOT_SNR_ONE][BAC_SNR_ONE_MSB:0]};
	assign snr_two_thr = {3'b000, regs_r[BAC_SLOT_SNR_TWO][BAC_SNR_TWO_MSB:0]};
	assign dc_thr = {2'b00, regs_r[BAC_SLOT_DC_THR][BAC_SIX_MSB:0]};

	// normal weight choice when no force bit is set
	assign tone_low = bac_below(rx_in.rssi, tone_thr, rx_in.measured_noise_level);
	assign snr_one_low = bac_below(rx_in.rssi, snr_one_thr, rx_in.measured_noise_level);
	assign snr_two_low = bac_below(rx_in.rssi, snr_two_thr, rx_in.measured_noise_level);
	assign normal_default = (rx_in.tone_interferer_present && tone_low) ||
		(!rx_in.tone_interferer_present && snr_one_low) ||
		(!rx_in.tone_interferer_present && rx_in.delay_spread_low && snr_two_low);

	assign req = avm_req.read | avm_req.write;
	assign {hit, slot} = bac_decode(avm_req.address);
	assign wr_en = avm_req.write & ~wait_r & hit;

	// waitrequest: high at rest, low for one cycle once a request is seen
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_r <= 1'b1;
		end else if (req && wait_r) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	// read data captured in the cycle before the answer; unmapped reads zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= '0;
		end else if (avm_req.read && wait_r && hit) begin
			rdata_r <= {{(BAC_DATA_W-BAC_REG_W){1'b0}}, regs_r[slot]};
		end else if (avm_req.read && wait_r) begin
			rdata_r <= '0;
		end
	end

	// register storage, all bits stored and read back
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < BAC_NUM_REGS; i++) begin
				regs_r[i] <= BAC_REG_RESET;
			end
		end else if (wr_en) begin
			regs_r[slot] <= avm_req.writedata[BAC_REG_W-1:0];
		end
	end

	// multipath_filter weight selection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			use_default_r <= 1'b1;
		end else if (regs_r[BAC_SLOT_TONE_THR][BAC_BIT_FORCE_DEFAULT]) begin
			use_default_r <= 1'b1;
		end else if (regs_r[BAC_SLOT_TONE_THR][BAC_BIT_FORCE_CALC]) begin
			use_default_r <= 1'b0;
		end else begin
			use_default_r <= normal_default;
		end
	end

	// dc offset compensation gate
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dc_comp_r <= 1'b0;
		end else begin
			dc_comp_r <= bac_above(rx_in.rssi, dc_thr, rx_in.measured_noise_level);
		end
	end

	// energy_detection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ed_r <= 1'b0;
		end else begin
			ed_r <= rx_in.rssi > rx_in.energy_detection_threshold;
		end
	end

	// acquisition criterion against live first threshold
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acq_r <= 1'b0;
		end else begin
			acq_r <= rx_in.sample_valid && rx_in.signal_quality_metric >= sq_thr_r &&
				(!regs_r[BAC_SLOT_ACQ_THR][BAC_BIT_ED_AND_SQ] || ed_r);
		end
	end

	// false_alarm_rate window: target is n*32 alarms per window
	assign far_target = BAC_FAR_CNT_W'(regs_r[BAC_SLOT_FAR_TARGET]) << BAC_FAR_SCALE_SHIFT;
	assign win_end = rx_in.sample_valid && win_cnt_r == BAC_FAR_CNT_W'(FAR_WINDOW - 1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			win_cnt_r <= '0;
		end else if (regs_r[BAC_SLOT_ACQ_THR][BAC_BIT_FAR_DISABLE] || win_end) begin
			win_cnt_r <= '0;
		end else if (rx_in.sample_valid) begin
			win_cnt_r <= win_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alarm_cnt_r <= '0;
		end else if (regs_r[BAC_SLOT_ACQ_THR][BAC_BIT_FAR_DISABLE] || win_end) begin
			alarm_cnt_r <= '0;
		end else if (rx_in.false_alarm && alarm_cnt_r != '1) begin
			alarm_cnt_r <= alarm_cnt_r + 1'b1;
		end
	end

	// live first threshold: loaded from the bus word on a write, since the register
	// itself only updates at that edge; fixed when disabled, adapted per window
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sq_thr_r <= BAC_SQ_THR_MIN;
		end else if (wr_en && slot == BAC_SLOT_ACQ_THR) begin
			sq_thr_r <= avm_req.writedata[BAC_SIX_MSB:0];
		end else if (regs_r[BAC_SLOT_ACQ_THR][BAC_BIT_FAR_DISABLE]) begin
			sq_thr_r <= regs_r[BAC_SLOT_ACQ_THR][BAC_SIX_MSB:0];
		end else if (win_end) begin
			if (alarm_cnt_r > far_target && sq_thr_r != BAC_SQ_THR_MAX) begin
				sq_thr_r <= sq_thr_r + BAC_SQ_THR_STEP;
			end else if (alarm_cnt_r < far_target && sq_thr_r != BAC_SQ_THR_MIN) begin
				sq_thr_r <= sq_thr_r - BAC_SQ_THR_STEP;
			end
		end
	end

	assign avm_waitrequest = wait_r;
	assign avm_readdata = rdata_r;
	// one driver for the whole control word
	assign ctrl_out = '{
		use_default_weights: use_default_r,
		dc_offset_comp_enable: dc_comp_r,
		energy_detection: ed_r,
		acquisition_detect: acq_r,
		sq1_threshold_live: sq_thr_r,
		sq1_threshold_verify: regs_r[BAC_SLOT_ACQ_TIMELINE][BAC_SIX_MSB:0],
		long_preamble_disable: regs_r[BAC_SLOT_ACQ_TIMELINE][BAC_BIT_LONG_DISABLE],
		diversity_metric_rssi: regs_r[BAC_SLOT_ACQ_TIMELINE][BAC_BIT_DIV_METRIC],
		preamble_lead: regs_r[BAC_SLOT_PRE_LEAD][BAC_SIX_MSB:0],
		preamble_lag: regs_r[BAC_SLOT_PRE_LAG][BAC_SIX_MSB:0],
		payload_lead: regs_r[BAC_SLOT_PAY_LEAD][BAC_SIX_MSB:0],
		payload_lag: regs_r[BAC_SLOT_PAY_LAG][BAC_SIX_MSB:0]
	};

endmodule : bac_config_bank
`default_nettype wire

//--- verification/bac_checker.sv
// assertion checker for the configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module bac_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire bac_pkg::bac_avm_req_t avm_req,
	input wire logic [bac_pkg::BAC_DATA_W-1:0] avm_readdata,
	input wire logic avm_waitrequest,
	input wire bac_pkg::bac_rx_in_t rx_in,
	input wire bac_pkg::bac_ctrl_out_t ctrl_out
);
	import bac_pkg::*;
	logic req;
	logic [31:0] cfg;
	assign req = avm_req.read | avm_req.write;
	assign cfg = {ctrl_out.sq1_threshold_verify, ctrl_out.long_preamble_disable,
		ctrl_out.diversity_metric_rssi, ctrl_out.preamble_lead, ctrl_out.preamble_lag,
		ctrl_out.payload_lead, ctrl_out.payload_lag};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	AST_WAIT_ANSWER: assert property (req && avm_waitrequest |=> !avm_waitrequest)
		else $error("request not answered");
	AST_WAIT_PULSE: assert property (!avm_waitrequest |=> avm_waitrequest)
		else $error("wait low too long");
	AST_IDLE_WAIT: assert property (!req |-> avm_waitrequest)
		else $error("wait low while idle");
	AST_RDATA_UPPER: assert property (avm_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_ED: assert property (1'b1 |=> ctrl_out.energy_detection ==
		($past(rx_in.rssi) > $past(rx_in.energy_detection_threshold)))
		else $error("energy detect wrong");
	AST_DC_OFF: assert property (rx_in.rssi <= rx_in.measured_noise_level |=>
		!ctrl_out.dc_offset_comp_enable)
		else $error("dc comp on below noise");
	AST_ACQ_VALID: assert property (!rx_in.sample_valid |=> !ctrl_out.acquisition_detect)
		else $error("detect without sample");
	AST_ACQ_METRIC: assert property (ctrl_out.acquisition_detect |->
		$past(rx_in.signal_quality_metric) >= $past(ctrl_out.sq1_threshold_live))
		else $error("detect below threshold");
	AST_CFG_HOLD: assert property (cfg != $past(cfg) |->
		$past(avm_req.write) && !$past(avm_waitrequest))
		else $error("config changed without write");
endmodule : bac_checker
bind bac_config_bank bac_checker u_chk (.clk(clk), .nrst(nrst), .avm_req(avm_req),
	.avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .rx_in(rx_in),
	.ctrl_out(ctrl_out));
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_top;
	import bac_pkg::*;
	logic clk;
	logic nrst;
	logic wreq;
	logic [7:0] d;
	logic [BAC_DATA_W-1:0] rdata;
	bac_avm_req_t req;
	bac_rx_in_t rx;
	bac_ctrl_out_t co;
	bac_ctrl_out_t exp_co;
	int err_count = 0;
	int checked = 0;
	localparam logic [7:0] IDX [13] = '{8'h4a, 8'h4c, 8'h4e, 8'h50, 8'h52, 8'h54, 8'h56,
		8'h58, 8'h5a, 8'h5c, 8'h5e, 8'h4b, 8'h60};
	localparam logic [7:0] WD [13] = '{8'h0a, 8'hf3, 8'h0c, 8'hc4, 8'he0, 8'h3f, 8'h20,
		8'h80, 8'h01, 8'hc5, 8'h08, 8'h77, 8'h55};
	localparam int FA [3] = '{0, 40, 32};
	localparam logic [5:0] FL [3] = '{6'h07, 6'h08, 6'h08};
	// tone register, tone, low spread, rssi, default expected
	localparam logic [18:0] WROW [10] = '{{8'h0a, 2'b10, 8'd14, 1'b1},
		{8'h0a, 2'b10, 8'd15, 1'b0}, {8'h0a, 2'b00, 8'd7, 1'b1}, {8'h0a, 2'b00, 8'd8, 1'b0},
		{8'h0a, 2'b01, 8'd16, 1'b1}, {8'h4a, 2'b00, 8'd40, 1'b1}, {8'h2a, 2'b10, 8'd0, 1'b0},
		{8'hca, 2'b10, 8'd40, 1'b1}, {8'h8a, 2'b10, 8'd15, 1'b0}, {8'h1f, 2'b10, 8'd35, 1'b1}};
	// acquisition register, metric, rssi, detect expected
	localparam logic [22:0] AROW [4] = '{{8'h83, 6'd3, 8'd0, 1'b1}, {8'h83, 6'd2, 8'd0, 1'b0},
		{8'hc3, 6'd3, 8'd0, 1'b0}, {8'hc3, 6'd3, 8'd10, 1'b1}};
	bac_config_bank #(.FAR_WINDOW(64)) u_dut (.clk(clk), .nrst(nrst), .avm_req(req),
		.avm_readdata(rdata), .avm_waitrequest(wreq), .rx_in(rx), .ctrl_out(co));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask : step
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		logic [9:0] a;
		int n;
		a = {idx, 2'b00};
		n = 0;
		@(posedge clk);
		req <= '{read: !w, write: w, address: a[8:0], writedata: {24'ha5a5a5, wd}};
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0);
		`CHK("wait cycles", 2, n)
		d = rdata[7:0];
		req <= '0;
	endtask : bus
	task automatic summarize();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		summarize();
	end
	initial begin
		nrst = 1'b0;
		req = '0;
		rx = '0;
		exp_co = '0;
		exp_co.use_default_weights = 1'b1;
		step(20);
		`CHK("rst ctrl", exp_co, co)
		nrst <= 1'b1;
		foreach (IDX[i]) bus(1'b1, IDX[i], WD[i]);
		foreach (IDX[i]) begin
			bus(1'b0, IDX[i], 8'h00);
			`CHK("readback", (IDX[i][0] || IDX[i] > 8'h5e) ? 8'h00 : WD[i], d)
		end
		`CHK("pre coef", 12'h83f, {co.preamble_lead, co.preamble_lag})
		`CHK("pay coef", 12'h800, {co.payload_lead, co.payload_lag})
		`CHK("timeline", 2'b11, {co.long_preamble_disable, co.diversity_metric_rssi})
		`CHK("verify", 6'h05, co.sq1_threshold_verify)
		`CHK("live", 6'h08, co.sq1_threshold_live)
		foreach (FA[i]) begin
			for (int s = 0; s < 64; s++) begin
				rx.sample_valid <= 1'b1;
				rx.false_alarm <= (s < FA[i]);
				@(posedge clk);
			end
			rx.sample_valid <= 1'b0;
			rx.false_alarm <= 1'b0;
			step(4);
			`CHK("far live", FL[i], co.sq1_threshold_live)
		end
		rx.measured_noise_level <= 8'h05;
		foreach (WROW[i]) begin
			bus(1'b1, 8'h4a, WROW[i][18:11]);
			{rx.tone_interferer_present, rx.delay_spread_low} <= WROW[i][10:9];
			rx.rssi <= WROW[i][8:1];
			step(3);
			`CHK("weights", WROW[i][0], co.use_default_weights)
		end
		rx.energy_detection_threshold <= 8'h09;
		for (int r = 9; r < 11; r++) begin
			rx.rssi <= 8'(r);
			step(3);
			`CHK("dc", r == 10, co.dc_offset_comp_enable)
			`CHK("ed", r == 10, co.energy_detection)
		end
		rx.sample_valid <= 1'b1;
		foreach (AROW[i]) begin
			bus(1'b1, 8'h5e, AROW[i][22:15]);
			rx.signal_quality_metric <= AROW[i][14:9];
			rx.rssi <= AROW[i][8:1];
			step(3);
			`CHK("acq", AROW[i][0], co.acquisition_detect)
			`CHK("live", 6'h03, co.sq1_threshold_live)
		end
		rx <= '0;
		step(2);
		nrst <= 1'b0;
		step(2);
		`CHK("rst ctrl", exp_co, co)
		nrst <= 1'b1;
		bus(1'b0, 8'h5c, 8'h00);
		`CHK("rst reg", 8'h00, d)
		summarize();
	end
endmodule : tb_top
`default_nettype wire
